// ---- verilog/adg_dma_addr_gen.v ----
`timescale 1ns/1ps
`include "adg_defs.vh"

// Function
// - Seven channels from two controllers; channel 4 only cascades 0-3.
// - Channels 0-3 move bytes to 8- or 16-bit memory.
// - Byte channels: address counter drives A0-A15 as byte address.
// - Byte channels: page register gives A16-A23, 16 MB reach.
// - Byte channel block is at most 64K bytes.
// - Channels 5-7 move 16-bit words only.
// - Word channels: counter shifted one place onto A1-A16.
// - Word channels: page register gives only A17-A23.
// - Word channel block is at most 128K bytes.
// - Word channels keep A0 at zero, never odd addresses.
// - Byte addresses wrap in 64K page; page never auto-increments.
// - Word addresses wrap in 128K page; page never auto-increments.
// - Controller runs at 4 MHz with one wait state per cycle.
// - Each single transfer takes 9 DMA clock cycles.
// - Channel 2 floppy, 3 SCSI; 0, 1, 5-7 free for bus adapters.
// - Page registers decoded at I/O 0080h-008Fh.
// - Second controller decoded at I/O 00C0h-00DFh.
module adg_dma_addr_gen (
	input wire clk,
	input wire sys_rst,
	input wire [15:0] ioAddr,
	input wire [7:0] ioWrData,
	input wire ioWr,
	input wire ioRd,
	output reg [7:0] ioRdData,
	input wire [7:0] dmaReq,
	input wire busGrant,
	output reg busReq,
	output reg [7:0] dmaAck,
	output reg [23:0] memAddr,
	output reg memRdStb,
	output reg memWrStb,
	output reg ioRdStb,
	output reg ioWrStb,
	output reg wordXfer,
	output reg termCount
);

localparam ST_IDLE = 2'd0;
localparam ST_WAIT = 2'd1;
localparam ST_XFER = 2'd2;
localparam ST_REL = 2'd3;

// ==========================================
// Channel state
reg [15:0] curAddr [0:7];
reg [15:0] curCount [0:7];
reg [7:0] pageReg [0:7];
reg [1:0] modeDir [0:7];
reg [7:0] armed_r;
reg flip1_r;
reg flip2_r;
reg [1:0] state_r;
reg [2:0] chan_r;
reg [3:0] tick_r;
reg [4:0] phase_r;
reg dmaTick_r;
integer i;
integer k;

// ==========================================
// 4 MHz enable from a fractional divider
// 25 is not a multiple of 4, so the phase accumulator gives an exact
// average rate at the price of uneven tick spacing.
wire [4:0] phaseSum;
assign phaseSum = phase_r + `ADG_DMA_MHZ;

always @(posedge clk) begin
	if (sys_rst) begin
		phase_r <= 5'h00;
		dmaTick_r <= 1'b0;
	end else if (phaseSum >= `ADG_CLK_MHZ) begin
		phase_r <= phaseSum - `ADG_CLK_MHZ;
		dmaTick_r <= 1'b1;
	end else begin
		phase_r <= phaseSum;
		dmaTick_r <= 1'b0;
	end
end

// ==========================================
// I/O decode
reg selC1;
reg selC2;
reg selPage;
reg [2:0] regChan;
reg regIsCnt;
reg pageHit;
reg [2:0] pageChan;
reg curFlip;
reg [15:0] ioOff;

always @* begin
	ioOff = 16'h0000;
	selC1 = 1'b0;
	selC2 = 1'b0;
	selPage = 1'b0;
	regChan = 3'd0;
	regIsCnt = 1'b0;
	pageHit = 1'b0;
	pageChan = 3'd0;
	if (ioAddr >= `ADG_C1_LO && ioAddr <= `ADG_C1_HI) begin
		ioOff = ioAddr - `ADG_C1_LO;
		selC1 = (ioOff[3] == 1'b0);
		regChan = {1'b0, ioOff[2:1]};
		regIsCnt = ioOff[0];
	end
	if (ioAddr >= `ADG_C2_LO && ioAddr <= `ADG_C2_HI) begin
		ioOff = ioAddr - `ADG_C2_LO;
		selC2 = (ioOff[4] == 1'b0);
		regChan = {1'b1, ioOff[3:2]};
		regIsCnt = ioOff[1];
	end
	if (ioAddr >= `ADG_PAGE_LO && ioAddr <= `ADG_PAGE_HI) begin
		selPage = 1'b1;
		case (ioAddr[3:0])
		4'h7: begin
			pageHit = 1'b1;
			pageChan = 3'd0;
		end
		4'h3: begin
			pageHit = 1'b1;
			pageChan = 3'd1;
		end
		4'h1: begin
			pageHit = 1'b1;
			pageChan = 3'd2;
		end
		4'h2: begin
			pageHit = 1'b1;
			pageChan = 3'd3;
		end
		4'hb: begin
			pageHit = 1'b1;
			pageChan = 3'd5;
		end
		4'h9: begin
			pageHit = 1'b1;
			pageChan = 3'd6;
		end
		4'ha: begin
			pageHit = 1'b1;
			pageChan = 3'd7;
		end
		default: pageHit = 1'b0;
		endcase
	end
	curFlip = selC2 ? flip2_r : flip1_r;
end

// Count high byte arms the channel; cascade slot never arms
wire armWr;
assign armWr = ioWr && (selC1 || selC2) && regIsCnt && curFlip &&
	regChan != `ADG_CASCADE_CH;

// ==========================================
// Priority pick, lowest channel wins
reg [2:0] pickChan;
reg pickValid;

always @* begin
	pickChan = 3'd0;
	pickValid = 1'b0;
	for (k = 7; k >= 0; k = k - 1) begin
		if (k != `ADG_CASCADE_CH && armed_r[k] && dmaReq[k]) begin
			pickChan = k[2:0];
			pickValid = 1'b1;
		end
	end
end

// ==========================================
// Address forming
wire isWord;
wire [23:0] nextMemAddr;
// Latched channel, so a request arriving during the grant wait
// cannot steal the slot that was already claimed.
assign isWord = chan_r[2];
// Word channels: page bit 0 is dropped and A0 is forced low.
assign nextMemAddr = isWord ?
	{pageReg[chan_r][7:1], curAddr[chan_r], 1'b0} :
	{pageReg[chan_r], curAddr[chan_r]};

// ==========================================
// Registers and transfer sequencer
always @(posedge clk) begin
	if (sys_rst) begin
		for (i = 0; i < 8; i = i + 1) begin
			curAddr[i] <= `ADG_ADDR_RST;
			curCount[i] <= `ADG_CNT_RST;
			pageReg[i] <= `ADG_PAGE_RST;
			modeDir[i] <= 2'b00;
		end
		armed_r <= 8'h00;
		flip1_r <= 1'b0;
		flip2_r <= 1'b0;
		state_r <= ST_IDLE;
		chan_r <= 3'd0;
		tick_r <= 4'h0;
		ioRdData <= 8'h00;
		busReq <= 1'b0;
		dmaAck <= 8'h00;
		memAddr <= 24'h000000;
		memRdStb <= 1'b0;
		memWrStb <= 1'b0;
		ioRdStb <= 1'b0;
		ioWrStb <= 1'b0;
		wordXfer <= 1'b0;
		termCount <= 1'b0;
	end else begin
		termCount <= 1'b0;
		// Software side; channel 4 slots accept writes but never arm
		if (ioWr && (selC1 || selC2)) begin
			if (regIsCnt) begin
				if (curFlip)
					curCount[regChan][15:8] <= ioWrData;
				else
					curCount[regChan][7:0] <= ioWrData;
			end else begin
				if (curFlip)
					curAddr[regChan][15:8] <= ioWrData;
				else
					curAddr[regChan][7:0] <= ioWrData;
			end
			if (armWr)
				armed_r[regChan] <= 1'b1;
		end
		if (ioWr && pageHit)
			pageReg[pageChan] <= ioWrData;
		if (ioWr && ioAddr == `ADG_C1_MODE)
			modeDir[{1'b0, ioWrData[1:0]}] <= ioWrData[3:2];
		if (ioWr && ioAddr == `ADG_C2_MODE)
			modeDir[{1'b1, ioWrData[1:0]}] <= ioWrData[3:2];
		if ((ioWr || ioRd) && selC1)
			flip1_r <= ~flip1_r;
		else if (ioWr && ioAddr == `ADG_C1_FLIP)
			flip1_r <= 1'b0;
		if ((ioWr || ioRd) && selC2)
			flip2_r <= ~flip2_r;
		else if (ioWr && ioAddr == `ADG_C2_FLIP)
			flip2_r <= 1'b0;
		if (ioRd) begin
			if (selC1 || selC2) begin
				if (regIsCnt)
					ioRdData <= curFlip ? curCount[regChan][15:8] :
						curCount[regChan][7:0];
				else
					ioRdData <= curFlip ? curAddr[regChan][15:8] :
						curAddr[regChan][7:0];
			end else if (selPage) begin
				ioRdData <= pageHit ? pageReg[pageChan] : 8'h00;
			end else begin
				ioRdData <= 8'h00;
			end
		end
		// Transfer side
		case (state_r)
		ST_IDLE: begin
			if (pickValid) begin
				chan_r <= pickChan;
				busReq <= 1'b1;
				state_r <= ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (busGrant && dmaTick_r) begin
				memAddr <= nextMemAddr;
				wordXfer <= isWord;
				dmaAck[chan_r] <= 1'b1;
				tick_r <= 4'h0;
				state_r <= ST_XFER;
			end
		end
		ST_XFER: begin
			if (dmaTick_r) begin
				tick_r <= tick_r + 4'h1;
				// Extra tick before strobe off is the wait state
				if (tick_r == `ADG_STB_ON_TICK) begin
					memWrStb <= modeDir[chan_r] == `ADG_MODE_TOMEM;
					ioRdStb <= modeDir[chan_r] == `ADG_MODE_TOMEM;
					memRdStb <= modeDir[chan_r] == `ADG_MODE_FROMMEM;
					ioWrStb <= modeDir[chan_r] == `ADG_MODE_FROMMEM;
				end
				if (tick_r == `ADG_STB_OFF_TICK) begin
					memRdStb <= 1'b0;
					memWrStb <= 1'b0;
					ioRdStb <= 1'b0;
					ioWrStb <= 1'b0;
				end
				if (tick_r == `ADG_XFER_TICKS - 4'h1) begin
					// 16-bit counter wraps; page is left alone
					curAddr[chan_r] <= curAddr[chan_r] + 16'h0001;
					curCount[chan_r] <= curCount[chan_r] - 16'h0001;
					if (curCount[chan_r] == 16'h0000) begin
						// Re-arm written in the same cycle wins
						if (!(armWr && regChan == chan_r))
							armed_r[chan_r] <= 1'b0;
						termCount <= 1'b1;
					end
					dmaAck <= 8'h00;
					busReq <= 1'b0;
					state_r <= ST_REL;
				end
			end
		end
		ST_REL: begin
			// Wait for the grant to drop so the CPU gets a turn
			if (!busGrant)
				state_r <= ST_IDLE;
		end
		default: state_r <= ST_IDLE;
		endcase
	end
end

endmodule // adg_dma_addr_gen

// ---- verilog/adg_defs.vh ----
`ifndef ADG_DEFS_VH
`define ADG_DEFS_VH
// ==========================================
// Clocking
`define ADG_CLK_MHZ 5'd25
`define ADG_DMA_MHZ 5'd4
`define ADG_XFER_TICKS 4'd9
`define ADG_STB_ON_TICK 4'd2
`define ADG_STB_OFF_TICK 4'd7
// ==========================================
// I/O windows
`define ADG_C1_LO 16'h0000
`define ADG_C1_HI 16'h000f
`define ADG_C2_LO 16'h00c0
`define ADG_C2_HI 16'h00df
`define ADG_PAGE_LO 16'h0080
`define ADG_PAGE_HI 16'h008f
`define ADG_C1_MODE 16'h000b
`define ADG_C1_FLIP 16'h000c
`define ADG_C2_MODE 16'h00d6
`define ADG_C2_FLIP 16'h00d8
// ==========================================
// Fields and reset values
`define ADG_CASCADE_CH 3'd4
`define ADG_MODE_DIR_BIT 2
`define ADG_MODE_TOMEM 2'b01
`define ADG_MODE_FROMMEM 2'b10
`define ADG_ADDR_RST 16'h0000
`define ADG_CNT_RST 16'h0000
`define ADG_PAGE_RST 8'h00
`endif

// ---- verif/adg_dma_addr_gen_assertions.sv ----
`timescale 1ns/1ps
// ==========================================
// Transfer checks
module adg_dma_addr_gen_chk (
	input wire clk,
	input wire sys_rst,
	input wire busGrant,
	input wire busReq,
	input wire [7:0] dmaAck,
	input wire [23:0] memAddr,
	input wire memRdStb,
	input wire memWrStb,
	input wire wordXfer,
	input wire termCount
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	wire ack = |dmaAck;
	wire stb = memRdStb | memWrStb;
	cascade_idle_a: assert property (dmaAck[4] == 1'b0)
		else $error("cascade slot acknowledged");
	ack_onehot_a: assert property ($onehot0(dmaAck))
		else $error("two acknowledges at once");
	word_chan_a: assert property (ack |-> wordXfer == |dmaAck[7:5])
		else $error("word flag disagrees with channel");
	word_even_a: assert property (ack && wordXfer |-> !memAddr[0])
		else $error("odd word address");
	ack_span_a: assert property ($rose(ack) |-> ##[52:60] $fell(ack))
		else $error("transfer length wrong");
	wait_state_a: assert property ($rose(ack) |-> (!stb)[*8])
		else $error("strobe too early");
	stb_in_ack_a: assert property (stb |-> ack)
		else $error("strobe outside transfer");
	grant_first_a: assert property ($rose(ack) |-> busReq && busGrant)
		else $error("transfer without bus");
	bus_release_a: assert property ($fell(ack) |-> !busReq)
		else $error("bus kept after transfer");
	addr_hold_a: assert property (ack && $past(ack) |-> $stable(memAddr))
		else $error("address moved in transfer");
	tc_pulse_a: assert property (termCount |=> !termCount)
		else $error("terminal count too long");
	cover property ($rose(ack) && wordXfer);
	cover property ($rose(memWrStb));
	cover property (termCount);
endmodule // adg_dma_addr_gen_chk

bind adg_dma_addr_gen adg_dma_addr_gen_chk chk_i (.*);

// ---- verif/adg_bus_partner.sv ----
`timescale 1ns/1ps
// ==========================================
// Processor side: grants the bus, slowly on demand
module adg_bus_partner (
	input wire clk,
	input wire sys_rst,
	input wire slow,
	input wire busReq,
	output logic busGrant
);
	int waitCnt_r;
	always @(posedge clk) begin
		if (sys_rst || !busReq) begin
			busGrant <= 1'b0;
			waitCnt_r <= 0;
		end else if (waitCnt_r >= (slow ? 9 : 0)) begin
			busGrant <= 1'b1;
		end else begin
			waitCnt_r <= waitCnt_r + 1;
		end
	end
endmodule // adg_bus_partner

// ---- verif/tb_adg_dma_addr_gen.sv ----
`timescale 1ns/1ps
module tb_adg_dma_addr_gen;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] ioAddr = 16'h0000;
	logic [7:0] ioWrData = 8'h00;
	logic ioWr = 1'b0;
	logic ioRd = 1'b0;
	logic [7:0] dmaReq = 8'h00;
	logic slowGrant = 1'b0;
	wire busGrant, busReq, memRdStb, memWrStb, wordXfer, termCount;
	wire ioRdStb, ioWrStb;
	wire [7:0] ioRdData;
	wire [7:0] dmaAck;
	wire [23:0] memAddr;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;
	int tcCnt = 0;
	adg_dma_addr_gen adg_dma_addr_gen_i (.clk(clk), .sys_rst(sys_rst),
		.ioAddr(ioAddr), .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd),
		.ioRdData(ioRdData), .dmaReq(dmaReq), .busGrant(busGrant),
		.busReq(busReq), .dmaAck(dmaAck), .memAddr(memAddr),
		.memRdStb(memRdStb), .memWrStb(memWrStb), .ioRdStb(ioRdStb),
		.ioWrStb(ioWrStb), .wordXfer(wordXfer), .termCount(termCount));
	adg_bus_partner adg_bus_partner_i (.clk(clk), .sys_rst(sys_rst),
		.slow(slowGrant), .busReq(busReq), .busGrant(busGrant));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (termCount === 1'b1)
			tcCnt++;
		if (cycles == 3000) begin
			error_cnt++;
			$display("MISMATCH %0t run hung", $time);
			give_verdict();
		end
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic ioW(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		ioAddr <= a;
		ioWrData <= d;
		ioWr <= 1'b1;
		@(posedge clk);
		ioWr <= 1'b0;
	endtask
	// Read data lands at the edge that takes the strobe
	task automatic ioR(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		ioAddr <= a;
		ioRd <= 1'b1;
		@(posedge clk);
		ioRd <= 1'b0;
		@(negedge clk);
		check(24'(ioRdData), 24'(exp));
	endtask
	// One single transfer; judged at falling edges where outputs settle
	task automatic xfer(input int ch, input logic [23:0] exp,
		input logic w, input logic [3:0] stb);
		int n;
		logic [3:0] seenStb;
		@(posedge clk);
		dmaReq[ch] <= 1'b1;
		n = 0;
		while (dmaAck[ch] !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		check(24'(dmaAck[ch]), 24'h000001);
		check(memAddr, exp);
		check(24'(wordXfer), 24'(w));
		repeat (25) @(negedge clk);
		// Order: memRd, memWr, ioRd, ioWr
		seenStb = {memRdStb, memWrStb, ioRdStb, ioWrStb};
		check(24'(seenStb), 24'(stb));
		@(posedge clk);
		dmaReq[ch] <= 1'b0;
		while (dmaAck[ch] === 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		check(24'(busReq), 24'h000000);
		repeat (3) @(negedge clk);
	endtask
	// Channel 2 as the floppy path, wrapping inside its page
	task automatic byteWrap();
		ioW(16'h000c, 8'h00);
		ioW(16'h0081, 8'h12);
		ioW(16'h000b, 8'h06);
		ioW(16'h0004, 8'hff);
		ioW(16'h0004, 8'hff);
		ioW(16'h0005, 8'h01);
		ioW(16'h0005, 8'h00);
		xfer(2, 24'h12ffff, 1'b0, 4'b0110);
		check(24'(tcCnt), 24'h000000);
		xfer(2, 24'h120000, 1'b0, 4'b0110);
		check(24'(tcCnt), 24'h000001);
		ioR(16'h0081, 8'h12);
		ioR(16'h0080, 8'h00);
		ioR(16'h0004, 8'h01);
		ioR(16'h0004, 8'h00);
		$display("byte wrap test done");
	endtask
	task automatic wordWrap();
		slowGrant <= 1'b1;
		ioW(16'h00d8, 8'h00);
		ioW(16'h008b, 8'h35);
		ioW(16'h00d6, 8'h09);
		ioW(16'h00c4, 8'hff);
		ioW(16'h00c4, 8'hff);
		ioW(16'h00c6, 8'h01);
		ioW(16'h00c6, 8'h00);
		xfer(5, 24'h35fffe, 1'b1, 4'b1001);
		xfer(5, 24'h340000, 1'b1, 4'b1001);
		check(24'(tcCnt), 24'h000002);
		ioR(16'h008b, 8'h35);
		ioR(16'h00c4, 8'h01);
		ioR(16'h00c4, 8'h00);
		$display("word wrap test done");
	endtask
	// Buffer split at a page edge; software moves the page by hand
	task automatic pageSplit();
		ioW(16'h000c, 8'h00);
		ioW(16'h0083, 8'h20);
		ioW(16'h000b, 8'h0d);
		ioW(16'h0002, 8'hff);
		ioW(16'h0002, 8'hff);
		ioW(16'h0003, 8'h00);
		ioW(16'h0003, 8'h00);
		xfer(1, 24'h20ffff, 1'b0, 4'b0000);
		ioW(16'h0083, 8'h21);
		ioW(16'h0002, 8'h00);
		ioW(16'h0002, 8'h00);
		ioW(16'h0003, 8'h00);
		ioW(16'h0003, 8'h00);
		xfer(1, 24'h210000, 1'b0, 4'b0000);
		check(24'(tcCnt), 24'h000004);
		$display("page split test done");
	endtask
	// Cascade slot may be loaded but must never start a transfer
	task automatic cascadeIdle();
		ioW(16'h00d8, 8'h00);
		ioW(16'h00c2, 8'h00);
		ioW(16'h00c2, 8'h00);
		dmaReq[4] <= 1'b1;
		repeat (20) @(negedge clk);
		check(24'(busReq), 24'h000000);
		check(24'(dmaAck), 24'h000000);
		@(posedge clk);
		dmaReq[4] <= 1'b0;
		$display("cascade test done");
	endtask
	task give_verdict();
		$display("compares %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		byteWrap();
		wordWrap();
		pageSplit();
		cascadeIdle();
		give_verdict();
	end
endmodule // tb_adg_dma_addr_gen
